// >>> verilog/serial_bus_sequencer.sv
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - acknowledge drives stored ack value on data
// - ack value used only after master receive
// - ack go bit starts acknowledge sequence
// - ack go bit cleared when sequence ends
// - ack go reads zero when idle
// - receive go clocks one byte in
// - receive go cleared after eighth bit
// - stop go makes a stop condition
// - stop go cleared when stop ends
// - repeated start generated, bit self-clears
// - start go makes a start condition
// - start go cleared when start ends
module serial_bus_sequencer (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic LINK_CLK,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [busseq_pkg::DATA_W-1:0] HWDATA,
    input wire logic HREADY,
    output logic [busseq_pkg::DATA_W-1:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic SERIAL_DATA_LINE_IN,
    output logic SERIAL_DATA_LINE_OUT,
    output logic SERIAL_DATA_LINE_OE,
    input wire logic SERIAL_CLOCK_LINE_IN,
    output logic SERIAL_CLOCK_LINE_OUT,
    output logic SERIAL_CLOCK_LINE_OE
);
    import busseq_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // register address match
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
        reg_hit = (a == ofs);
    endfunction : reg_hit

    // line levels per step: {last, clock, data}; one means released
    function automatic logic [2:0] step_lines(input op_t op, input logic [2:0] st, input logic a);
        logic [2:0] v;
        v = 3'h7;
        unique case (op)
            OP_START: begin
                case (st)
                    3'h0: v = 3'h3;
                    3'h1: v = 3'h2;
                    default: v = 3'h4;
                endcase
            end
            OP_RSTART: begin
                case (st)
                    3'h0: v = 3'h1;
                    3'h1: v = 3'h3;
                    3'h2: v = 3'h2;
                    default: v = 3'h4;
                endcase
            end
            OP_STOP: begin
                case (st)
                    3'h0: v = 3'h0;
                    3'h1: v = 3'h2;
                    default: v = 3'h7;
                endcase
            end
            OP_RECV: begin
                case (st)
                    3'h0: v = 3'h1;
                    3'h1: v = 3'h3;
                    3'h2: v = 3'h3;
                    default: v = 3'h5;
                endcase
            end
            OP_ACK: begin
                case (st)
                    3'h0: v = {2'b00, a};
                    3'h1: v = {2'b01, a};
                    3'h2: v = {2'b01, a};
                    3'h3: v = {2'b00, a};
                    default: v = 3'h5;
                endcase
            end
            default: v = 3'h7;
        endcase
        step_lines = v;
    endfunction : step_lines

    // ------------------------------------------------------------
    // core domain declarations
    // ------------------------------------------------------------
    logic accept; // address phase taken this edge
    logic wr_pend_r; // write data phase follows
    logic [7:0] addr_r; // latched write offset
    logic write_ctrl; // control word written this cycle
    logic [4:0] go_r; // self-clearing request bits
    logic ack_val_r; // stored acknowledge value
    logic busy_r; // one event is in flight
    logic ack_ok_r; // a byte was received and not yet answered
    logic [7:0] rx_data_r; // last received byte
    op_t cmd_op_r; // event handed to the link side
    logic cmd_ack_r; // ack value handed with it
    logic req_tgl_r; // flips once per request
    logic done_s; // link completion toggle, synchronised
    logic done_seen_r; // previous done_s
    logic done_edge; // completion event in core domain
    logic [4:0] new_go; // bit chosen from the write
    op_t new_op; // event chosen from the write
    logic launch; // request accepted this cycle
    logic [15:0] ctrl_view; // control word as read back

    // ------------------------------------------------------------
    // link domain declarations
    // ------------------------------------------------------------
    logic lrst_a_r; // reset release, first stage
    logic lrst_b_r; // reset release, second stage
    logic link_rst_n; // link reset, synchronous release
    logic req_s; // request toggle, synchronised
    logic req_seen_r; // previous req_s
    logic req_edge; // new request in link domain
    logic sda_s; // data line, synchronised
    logic scl_s; // clock line, synchronised
    link_state_t l_state_r; // sequencer state
    op_t l_op_r; // event being sequenced
    logic l_ack_r; // ack value being sent
    logic [2:0] l_step_r; // step within a bit
    logic [2:0] l_bit_r; // data bit count for receive
    logic [7:0] l_rx_r; // shift register of received bits
    logic done_tgl_r; // flips once per finished event
    logic scl_lvl_r; // clock line level, one released
    logic sda_lvl_r; // data line level, one released
    logic scl_oe_r; // clock line pulled low
    logic sda_oe_r; // data line pulled low
    logic [2:0] lines; // table entry for this step
    tick_if tk ();

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    assign accept = HSEL && HREADY && HTRANS[1];

    // address phase: hold write target for the data phase
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            wr_pend_r <= 1'b0;
            addr_r <= 8'h00;
        end else begin
            wr_pend_r <= accept && HWRITE && (HSIZE == WORD_SIZE);
            addr_r <= HADDR[7:0];
        end
    end

    // read data is registered in the address phase, so no wait states
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            HRDATA <= RDATA_RESET;
        end else if (accept && !HWRITE) begin
            if (reg_hit(HADDR[7:0], OFS_CONTROL)) begin
                HRDATA <= {16'h0000, ctrl_view};
            end else if (reg_hit(HADDR[7:0], OFS_RX_DATA)) begin
                HRDATA <= {24'h000000, rx_data_r};
            end else if (reg_hit(HADDR[7:0], OFS_STATUS)) begin
                HRDATA <= {30'h0, ack_ok_r, busy_r};
            end else begin
                HRDATA <= RDATA_RESET; // unmapped reads as zero
            end
        end
    end

    // always ready, always okay
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    assign ctrl_view = {10'h000, ack_val_r, go_r};
    assign write_ctrl = wr_pend_r && reg_hit(addr_r, OFS_CONTROL);

    // ------------------------------------------------------------
    // request selection
    // ------------------------------------------------------------
    // one bit wins if software sets several; lowest bit first
    always_comb begin
        new_go = GO_RESET;
        new_op = OP_START;
        if (HWDATA[BIT_START]) begin
            new_go[BIT_START] = 1'b1;
            new_op = OP_START;
        end else if (HWDATA[BIT_RSTART]) begin
            new_go[BIT_RSTART] = 1'b1;
            new_op = OP_RSTART;
        end else if (HWDATA[BIT_STOP]) begin
            new_go[BIT_STOP] = 1'b1;
            new_op = OP_STOP;
        end else if (HWDATA[BIT_RECV]) begin
            new_go[BIT_RECV] = 1'b1;
            new_op = OP_RECV;
        end else if (HWDATA[BIT_ACKGO] && ack_ok_r) begin
            new_go[BIT_ACKGO] = 1'b1;
            new_op = OP_ACK;
        end
    end

    // requests written while busy are dropped; software must wait
    assign launch = write_ctrl && !busy_r && (new_go != GO_RESET);

    // stored ack value may be rewritten at any time
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ack_val_r <= 1'b0;
        end else if (write_ctrl) begin
            ack_val_r <= HWDATA[BIT_ACKVAL];
        end
    end

    // go bits: set on launch, cleared by the link's completion
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            go_r <= GO_RESET;
            busy_r <= 1'b0;
        end else if (launch) begin
            go_r <= new_go;
            busy_r <= 1'b1;
        end else if (done_edge) begin
            go_r <= GO_RESET;
            busy_r <= 1'b0;
        end
    end

    // command words stay still until the next launch
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            cmd_op_r <= OP_START;
            cmd_ack_r <= 1'b0;
            req_tgl_r <= 1'b0;
        end else if (launch) begin
            cmd_op_r <= new_op;
            cmd_ack_r <= HWDATA[BIT_ACKVAL];
            req_tgl_r <= ~req_tgl_r;
        end
    end

    // completion toggle back into the core domain
    sync_2ff #(.W(1)) u_done_sync (
        .clk(CORE_CLK),
        .rst_n(RESETN),
        .d(done_tgl_r),
        .q(done_s)
    );

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            done_seen_r <= 1'b0;
        end else begin
            done_seen_r <= done_s;
        end
    end

    assign done_edge = done_s ^ done_seen_r;

    // received byte is stable on the link side once done toggles
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rx_data_r <= RX_RESET;
            ack_ok_r <= 1'b0;
        end else if (done_edge) begin
            if (cmd_op_r == OP_RECV) begin
                rx_data_r <= l_rx_r;
                ack_ok_r <= 1'b1;
            end else begin
                ack_ok_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // link domain: reset and inputs
    // ------------------------------------------------------------
    // assert at once, release on the link clock
    always_ff @(posedge LINK_CLK or negedge RESETN) begin
        if (!RESETN) begin
            lrst_a_r <= 1'b0;
            lrst_b_r <= 1'b0;
        end else begin
            lrst_a_r <= 1'b1;
            lrst_b_r <= lrst_a_r;
        end
    end

    assign link_rst_n = lrst_b_r;

    sync_2ff #(.W(3)) u_link_sync (
        .clk(LINK_CLK),
        .rst_n(link_rst_n),
        .d({req_tgl_r, SERIAL_DATA_LINE_IN, SERIAL_CLOCK_LINE_IN}),
        .q({req_s, sda_s, scl_s})
    );

    always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            req_seen_r <= 1'b0;
        end else begin
            req_seen_r <= req_s;
        end
    end

    assign req_edge = req_s ^ req_seen_r;

    // ------------------------------------------------------------
    // link domain: sequencer
    // ------------------------------------------------------------
    assign lines = step_lines(l_op_r, l_step_r, l_ack_r);
    assign tk.run = (l_state_r == LS_STEP);
    // a slave holding the clock low delays the high phase
    assign tk.hold = scl_lvl_r && !scl_s;

    quarter_tick u_tick (
        .clk(LINK_CLK),
        .rst_n(link_rst_n),
        .tk(tk)
    );

    // walk the step table one quarter bit at a time
    always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            l_state_r <= LS_IDLE;
            l_op_r <= OP_START;
            l_ack_r <= 1'b0;
            l_step_r <= 3'h0;
            l_bit_r <= 3'h0;
            l_rx_r <= RX_RESET;
            done_tgl_r <= 1'b0;
        end else begin
            unique case (l_state_r)
                LS_IDLE: begin
                    if (req_edge) begin
                        l_op_r <= cmd_op_r;
                        l_ack_r <= cmd_ack_r;
                        l_step_r <= 3'h0;
                        l_bit_r <= 3'h0;
                        l_state_r <= LS_STEP;
                    end
                end
                LS_STEP: begin
                    if (tk.tick) begin
                        // sample with the clock line high
                        if (l_op_r == OP_RECV && l_step_r == RX_SAMPLE_STEP) begin
                            l_rx_r <= {l_rx_r[6:0], sda_s};
                        end
                        if (!lines[2]) begin
                            l_step_r <= l_step_r + 3'h1;
                        end else if (l_op_r == OP_RECV && l_bit_r != RX_LAST_BIT) begin
                            l_bit_r <= l_bit_r + 3'h1;
                            l_step_r <= 3'h0;
                        end else begin
                            l_state_r <= LS_FINISH;
                        end
                    end
                end
                LS_FINISH: begin
                    done_tgl_r <= ~done_tgl_r;
                    l_state_r <= LS_IDLE;
                end
            endcase
        end
    end

    // line drive follows the table; idle lines keep the levels of the last step
    always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            scl_lvl_r <= 1'b1;
            sda_lvl_r <= 1'b1;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (l_state_r == LS_STEP && tk.tick) begin
            scl_lvl_r <= lines[1];
            sda_lvl_r <= lines[0];
            scl_oe_r <= ~lines[1];
            sda_oe_r <= ~lines[0];
        end
    end

    assign SERIAL_CLOCK_LINE_OUT = scl_lvl_r;
    assign SERIAL_CLOCK_LINE_OE = scl_oe_r;
    assign SERIAL_DATA_LINE_OUT = sda_lvl_r;
    assign SERIAL_DATA_LINE_OE = sda_oe_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_done_seen;
        done_edge ##1 (go_r == GO_RESET);
    endsequence

    property p_ack_drive;
        @(posedge LINK_CLK) disable iff (!link_rst_n)
        (l_state_r == LS_STEP && l_op_r == OP_ACK && l_step_r == 3'h2) |-> (sda_lvl_r == l_ack_r);
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("ack level differs");

    property p_ack_needs_rx;
        @(posedge CORE_CLK) disable iff (!RESETN)
        $rose(go_r[BIT_ACKGO]) |-> $past(ack_ok_r) && !$past(busy_r);
    endproperty
    a_ack_needs_rx: assert property (p_ack_needs_rx) else $error("ack without byte");

    property p_ack_launch;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (launch && new_op == OP_ACK) |=> go_r[BIT_ACKGO] && busy_r && $changed(req_tgl_r);
    endproperty
    a_ack_launch: assert property (p_ack_launch) else $error("ack not launched");

    property p_go_clear;
        @(posedge CORE_CLK) disable iff (!RESETN)
        busy_r ##0 s_done_seen |-> !busy_r;
    endproperty
    a_go_clear: assert property (p_go_clear) else $error("go not cleared");

    property p_idle_zero;
        @(posedge CORE_CLK) disable iff (!RESETN)
        $fell(busy_r) |-> (go_r == GO_RESET) && $past(done_edge);
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("go without event");

    property p_recv_start;
        @(posedge LINK_CLK) disable iff (!link_rst_n)
        (l_state_r == LS_IDLE && req_edge && cmd_op_r == OP_RECV) |=> (l_state_r == LS_STEP);
    endproperty
    a_recv_start: assert property (p_recv_start) else $error("receive not run");

    property p_recv_eight;
        @(posedge LINK_CLK) disable iff (!link_rst_n)
        (l_state_r == LS_FINISH && l_op_r == OP_RECV) |-> (l_bit_r == RX_LAST_BIT);
    endproperty
    a_recv_eight: assert property (p_recv_eight) else $error("receive not 8 bits");

    property p_stop_lines;
        @(posedge LINK_CLK) disable iff (!link_rst_n)
        (l_state_r == LS_FINISH && l_op_r == OP_STOP) |-> scl_lvl_r && sda_lvl_r && !sda_oe_r;
    endproperty
    a_stop_lines: assert property (p_stop_lines) else $error("stop lines wrong");

    property p_start_lines;
        @(posedge LINK_CLK) disable iff (!link_rst_n)
        (l_state_r == LS_FINISH && (l_op_r == OP_START || l_op_r == OP_RSTART))
            |-> scl_oe_r && sda_oe_r ##1 (l_state_r == LS_IDLE);
    endproperty
    a_start_lines: assert property (p_start_lines) else $error("start lines wrong");

    property p_done_clear;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (busy_r && done_edge) |=> (go_r == GO_RESET) ##[1:4] !done_edge;
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("bit not self-cleared");
endmodule : serial_bus_sequencer
`default_nettype wire

// >>> verilog/busseq_pkg.sv
// ------------------------------------------------------------
// shared constants for the serial bus sequencer
// ------------------------------------------------------------
package busseq_pkg;
    // bus data width
    localparam int DATA_W = 32;
    // register byte offsets
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_RX_DATA = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    // control register bit positions
    localparam int BIT_START = 0;
    localparam int BIT_RSTART = 1;
    localparam int BIT_STOP = 2;
    localparam int BIT_RECV = 3;
    localparam int BIT_ACKGO = 4;
    localparam int BIT_ACKVAL = 5;
    // status register bit positions
    localparam int BIT_BUSY = 0;
    localparam int BIT_RX_HELD = 1;
    // values after reset
    localparam logic [4:0] GO_RESET = 5'h00;
    localparam logic [7:0] RX_RESET = 8'h00;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    // only whole-word writes are taken; reads of any size are served
    localparam logic [2:0] WORD_SIZE = 3'h2;
    // link clocks per quarter bit, minus one
    localparam logic [3:0] QTR_LAST = 4'h3;
    // last data bit index of a received byte
    localparam logic [2:0] RX_LAST_BIT = 3'h7;
    // step at which received data is sampled
    localparam logic [2:0] RX_SAMPLE_STEP = 3'h2;
    // bus events that software can request
    typedef enum logic [2:0] {
        OP_START = 3'h0,
        OP_RSTART = 3'h1,
        OP_STOP = 3'h2,
        OP_RECV = 3'h3,
        OP_ACK = 3'h4
    } op_t;
    // link sequencer states
    typedef enum logic [2:0] {
        LS_IDLE = 3'b001,
        LS_STEP = 3'b010,
        LS_FINISH = 3'b100
    } link_state_t;
endpackage : busseq_pkg

// >>> verilog/tick_if.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// quarter-bit pacing between sequencer and divider
// ------------------------------------------------------------
interface tick_if;
    logic run; // divider may count
    logic hold; // freeze while the clock line is held low
    logic tick; // one quarter bit has elapsed
    modport ctl (output run, output hold, input tick);
    modport gen (input run, input hold, output tick);
endinterface : tick_if
`default_nettype wire

// >>> verilog/sync_2ff.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// two-stage synchroniser; stage one feeds stage two only
// ------------------------------------------------------------
module sync_2ff #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r; // may go metastable, read by q only

    // shift through both stages
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : sync_2ff
`default_nettype wire

// >>> verilog/quarter_tick.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// quarter-bit tick divider on the link clock
// ------------------------------------------------------------
module quarter_tick
    import busseq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    tick_if.gen tk
);
    logic [3:0] cnt_r; // link clocks into this quarter

    // count while running, freeze while held
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 4'h0;
            tk.tick <= 1'b0;
        end else if (!tk.run) begin
            cnt_r <= 4'h0;
            tk.tick <= 1'b0;
        end else if (tk.hold) begin
            tk.tick <= 1'b0;
        end else if (cnt_r == QTR_LAST) begin
            cnt_r <= 4'h0;
            tk.tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 4'h1;
            tk.tick <= 1'b0;
        end
    end
endmodule : quarter_tick
`default_nettype wire

// >>> dv/bus_slave_model.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// far-side slave: shifts one byte out, captures the answer
// ------------------------------------------------------------
module bus_slave_model (
    input wire logic scl, // clock line wire level
    input wire logic sda, // data line wire level
    input wire logic [7:0] tx, // byte to send, msb first
    input wire logic arm, // high while a byte may go out
    output logic pull, // high pulls the data line low
    output logic ack_bit // data level on the ninth clock
);
    logic [3:0] idx = 4'h0; // bits already shifted out; known before the first arm
    // next bit after each falling clock, so data is steady while high
    always @(negedge scl or negedge arm) begin
        if (!arm) begin
            idx <= 4'h0;
        end else if (idx < 4'h8) begin
            idx <= idx + 4'h1;
        end
    end
    // released once the byte is out, so the pull-up shows
    assign pull = arm && (idx < 4'h8) && !tx[3'h7 - idx[2:0]];
    // the master's answer is taken as the clock rises after the byte
    always @(posedge scl) begin
        if (arm && idx == 4'h8) begin
            ack_bit <= sda;
        end
    end
endmodule : bus_slave_model
`default_nettype wire

// >>> dv/i2c_master_bus_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_master_bus_sequencer_tb;
    import busseq_pkg::*;
    logic CORE_CLK, RESETN, LINK_CLK, HSEL, HWRITE, arm, av;
    logic [31:0] HADDR, HWDATA, HRDATA, q;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    logic [7:0] tx;
    logic HREADYOUT, HRESP, sda_oe, scl_oe, pull, ack_bit, sda_out, scl_out;
    wire sda = !(sda_oe | pull); // open drain, pulled up
    wire scl = !scl_oe;
    int n_errors = 0, n_tests = 0, seed = 19129, n_start = 0, n_stop = 0;
    // ------------------------------------------------------------
    // clocks, wire monitor, design and partner
    // ------------------------------------------------------------
    initial begin
        CORE_CLK = 1'b0;
        forever #5 CORE_CLK = !CORE_CLK;
    end
    // link clock with an odd phase offset to the core clock
    initial begin
        LINK_CLK = 1'b0;
        #1.7;
        forever #3 LINK_CLK = !LINK_CLK;
    end
    always @(negedge sda) if (scl === 1'b1 && RESETN === 1'b1) n_start++;
    always @(posedge sda) if (scl === 1'b1 && RESETN === 1'b1) n_stop++;
    serial_bus_sequencer i_serial_bus_sequencer (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .LINK_CLK(LINK_CLK),
        .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .SERIAL_DATA_LINE_IN(sda), .SERIAL_DATA_LINE_OUT(sda_out), .SERIAL_DATA_LINE_OE(sda_oe),
        .SERIAL_CLOCK_LINE_IN(scl), .SERIAL_CLOCK_LINE_OUT(scl_out), .SERIAL_CLOCK_LINE_OE(scl_oe));
    bus_slave_model i_bus_slave_model (.scl(scl), .sda(sda), .tx(tx), .arm(arm), .pull(pull), .ack_bit(ack_bit));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // control word once every go bit has self-cleared
    function automatic logic [31:0] ctrl_idle(input logic a);
        return {26'h0, a, 5'h0};
    endfunction : ctrl_idle
    // one single word transfer; read data lands in q
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {24'h0, a};
        do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
        q = HRDATA;
    endtask : xfer
    // request one bus event, then poll until its go bit drops
    task go(input logic [31:0] d, input int b);
        int k;
        k = 0;
        xfer(1'b1, OFS_CONTROL, d);
        do begin
            xfer(1'b0, OFS_CONTROL, 32'h0);
            k++;
        end while (q[b] === 1'b1 && k < 400);
    endtask : go
    task wrap_up;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {HSEL, HTRANS, HWRITE, HADDR, HWDATA, arm, tx, RESETN} = '0;
        HSIZE = WORD_SIZE;
        repeat (12) @(posedge CORE_CLK);
        RESETN <= 1'b1;
        HSEL <= 1'b1;
        repeat (4) @(posedge CORE_CLK);
        xfer(1'b0, OFS_CONTROL, 32'h0);
        chk(q, ctrl_idle(1'b0), "control after reset");
        xfer(1'b0, 8'h0c, 32'h0);
        chk(q, 32'h0, "unmapped read");
        chk({31'h0, HRESP}, 32'h0, "okay response");
        $display("test registers done");
        go(32'h1, BIT_START);
        chk(q, ctrl_idle(1'b0), "start go clear");
        chk(n_start, 32'h1, "start on wire");
        go(32'h2, BIT_RSTART);
        chk(q, ctrl_idle(1'b0), "repeated start go clear");
        chk(n_start, 32'h2, "repeated start on wire");
        $display("test starts done");
        // two bytes: nack after the first, ack after the second
        for (int i = 0; i < 2; i++) begin
            av = !i[0];
            @(posedge CORE_CLK);
            tx <= 8'($random(seed));
            arm <= 1'b1;
            // every control write also rewrites the stored ack value
            go({26'h0, av, 5'h08}, BIT_RECV);
            chk(q, ctrl_idle(av), "receive go clear");
            xfer(1'b0, OFS_RX_DATA, 32'h0);
            chk(q, {24'h0, tx}, "received byte");
            go({26'h0, av, 5'h10}, BIT_ACKGO);
            chk(q, ctrl_idle(av), "ack go clear");
            chk({31'h0, ack_bit}, {31'h0, av}, "ack level");
            @(posedge CORE_CLK);
            arm <= 1'b0;
        end
        // an acknowledge with no byte received is not started
        xfer(1'b1, OFS_CONTROL, 32'h10);
        xfer(1'b0, OFS_CONTROL, 32'h0);
        chk(q, ctrl_idle(1'b0), "ack refused");
        $display("test receive done");
        go(32'h4, BIT_STOP);
        chk(q, ctrl_idle(1'b0), "stop go clear");
        chk(n_stop, 32'h1, "stop on wire");
        chk({30'h0, scl, sda}, 32'h3, "lines released");
        chk({30'h0, scl_out, sda_out}, 32'h3, "line levels");
        $display("test stop done");
        wrap_up();
    end
    // hang guard, far beyond the few hundred core cycles the run needs
    initial begin
        #300000;
        n_errors++;
        $display("mismatch at %0t: timeout", $time);
        wrap_up();
    end
endmodule : i2c_master_bus_sequencer_tb
`default_nettype wire
